//--- shared/irc_pkg.sv
// Shared types and constants for the interrupt request controller.
// Assumes one system clock domain; all users refer to names as irc_pkg::name.
package irc_pkg;

  // ---------------------------------------------------------------
  // Sizes and codes
  // ---------------------------------------------------------------
  localparam int NUM_PERIPH = 16;
  localparam int NUM_EXT = 8;
  localparam int NUM_ELINK = 2;
  localparam int PRIO_W = 4;
  localparam int FILT_SEL_W = 2;
  // Source ordering: peripherals, then pins, then software, then event link.
  localparam int EXT_BASE = NUM_PERIPH;
  localparam int SW_IDX = NUM_PERIPH + NUM_EXT;
  localparam int ELINK_BASE = SW_IDX + 1;
  localparam int NUM_SRC = ELINK_BASE + NUM_ELINK;
  localparam int VEC_W = 5;
  // Reset values.
  localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
  localparam logic [VEC_W-1:0] VEC_RST = 5'h00;
  // Filter sample intervals in clocks, selected per pin by filt_sel.
  localparam logic [5:0] FILT_DIV1 = 6'h01;
  localparam logic [5:0] FILT_DIV8 = 6'h08;
  localparam logic [5:0] FILT_DIV32 = 6'h20;
  localparam logic [5:0] FILT_DIV64 = 6'h3f;

  // Pin detection modes.
  typedef enum logic [1:0] {
    IRC_DET_LOW = 2'b00,
    IRC_DET_FALL = 2'b01,
    IRC_DET_RISE = 2'b10,
    IRC_DET_BOTH = 2'b11
  } irc_det_t;

  // Answer presented to the CPU core.
  typedef struct packed {
    logic req;
    logic fast;
    logic [VEC_W-1:0] vec;
    logic [PRIO_W-1:0] prio;
  } irc_cpu_req_t;

  // Non-maskable source inputs, all same-clock logic except the pin.
  typedef struct packed {
    logic osc_stop;
    logic wdt_underflow;
    logic wdt_refresh_err;
    logic volt_mon_one;
    logic volt_mon_two;
  } irc_nmi_src_t;

endpackage : irc_pkg

//--- rtl/irc_pin_filter.sv
// One external pin: three-stage synchroniser and a sampling noise filter.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/100ps
module irc_pin_filter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pin and configuration
  input wire logic pin_in,
  input wire logic filt_en,
  input wire logic [irc_pkg::FILT_SEL_W-1:0] filt_sel,
  // Filtered level
  output logic level_out
);

  // ---------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic sync_lvl_r;
  logic sync_lvl_nxt;
  logic [5:0] div_r;
  logic [5:0] div_nxt;
  logic [2:0] samp_r;
  logic [2:0] samp_nxt;
  logic out_r;
  logic out_nxt;
  logic [5:0] div_lim;

  // Stage one feeds stage two only; a change counts once two and three agree.
  always_comb begin
    sync_nxt = {sync_r[1:0], pin_in};
    sync_lvl_nxt = sync_lvl_r;
    if (sync_r[1] == sync_r[2]) begin
      sync_lvl_nxt = sync_r[2];
    end
  end

  // ---------------------------------------------------------------
  // Filter: three equal samples taken at the selected interval
  // ---------------------------------------------------------------
  always_comb begin
    case (filt_sel)
      2'h0: div_lim = irc_pkg::FILT_DIV1;
      2'h1: div_lim = irc_pkg::FILT_DIV8;
      2'h2: div_lim = irc_pkg::FILT_DIV32;
      default: div_lim = irc_pkg::FILT_DIV64;
    endcase
  end

  // A slow interval rejects longer glitches at the cost of longer latency.
  always_comb begin
    div_nxt = div_r + 6'h01;
    samp_nxt = samp_r;
    out_nxt = out_r;
    if (div_nxt >= div_lim) begin
      div_nxt = 6'h00;
      samp_nxt = {samp_r[1:0], sync_lvl_r};
    end
    if (!filt_en) begin
      out_nxt = sync_lvl_r;
    end else if (samp_r == 3'h7) begin
      out_nxt = 1'b1;
    end else if (samp_r == 3'h0) begin
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_r <= 3'h7;
      sync_lvl_r <= 1'b1;
      div_r <= 6'h00;
      samp_r <= 3'h7;
      out_r <= 1'b1;
    end else if (clk_en) begin
      sync_r <= sync_nxt;
      sync_lvl_r <= sync_lvl_nxt;
      div_r <= div_nxt;
      samp_r <= samp_nxt;
      out_r <= out_nxt;
    end
  end

  assign level_out = out_r;

endmodule // irc_pin_filter

//--- rtl/irc_arbiter.sv
// Priority arbiter over all maskable sources.
// Assumes requests are already gated by enables; purely combinational.
`timescale 1ns/100ps
module irc_arbiter #(
  parameter int NUM_SRC = irc_pkg::NUM_SRC
) (
  // Candidates
  input wire logic [NUM_SRC-1:0] cand,
  input wire logic [NUM_SRC*irc_pkg::PRIO_W-1:0] prio_flat,
  // Winner
  output logic win_valid,
  output logic [irc_pkg::VEC_W-1:0] win_vec,
  output logic [irc_pkg::PRIO_W-1:0] win_prio
);

  // ---------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------
  // Scan downward with a >= compare so that on ties the lowest vector wins.
  always_comb begin
    logic [irc_pkg::PRIO_W-1:0] p;
    p = '0;
    win_valid = 1'b0;
    win_vec = irc_pkg::VEC_RST;
    win_prio = irc_pkg::PRIO_RST;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      p = prio_flat[i*irc_pkg::PRIO_W +: irc_pkg::PRIO_W];
      if (cand[i] && p != irc_pkg::PRIO_RST && (!win_valid || p >= win_prio)) begin
        win_valid = 1'b1;
        win_vec = irc_pkg::VEC_W'(i);
        win_prio = p;
      end
    end
  end

endmodule // irc_arbiter

//--- rtl/irc_top.sv
// Interrupt request controller: detection, pending, arbitration, routing.
// Assumes the CPU core and the transfer controller run on ref_clk and
// acknowledge with one-cycle strobes, the CPU's carrying the vector taken.
`timescale 1ns/100ps

module irc_top #(
  parameter int NUM_PERIPH = irc_pkg::NUM_PERIPH,
  parameter int NUM_EXT = irc_pkg::NUM_EXT,
  parameter int NUM_ELINK = irc_pkg::NUM_ELINK
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Request sources
  input wire logic [NUM_PERIPH-1:0] periph_req,
  input wire logic [NUM_PERIPH-1:0] periph_edge_mode,
  input wire logic [NUM_EXT-1:0] ext_request_pin,
  input wire logic [NUM_ELINK-1:0] event_link_unit_evt,
  input wire logic sw_trigger_wr,
  // Pin configuration
  input wire logic [NUM_EXT*2-1:0] ext_det_mode,
  input wire logic [NUM_EXT-1:0] ext_filt_en,
  input wire logic [NUM_EXT*irc_pkg::FILT_SEL_W-1:0] ext_filt_sel,
  // Per-source control
  input wire logic [irc_pkg::NUM_SRC-1:0] src_enable,
  input wire logic [irc_pkg::NUM_SRC*irc_pkg::PRIO_W-1:0] src_prio,
  input wire logic [irc_pkg::NUM_SRC-1:0] transfer_trigger_enable_reg,
  input wire logic [irc_pkg::NUM_SRC-1:0] sw_clear,
  input wire logic fast_en,
  input wire logic [irc_pkg::VEC_W-1:0] fast_vec,
  // Non-maskable sources
  input wire logic nmi_pin,
  input wire logic nmi_rising,
  input wire logic nmi_filt_en,
  input wire logic [irc_pkg::FILT_SEL_W-1:0] nmi_filt_sel,
  input wire logic nmi_enable,
  input wire irc_pkg::irc_nmi_src_t nmi_src,
  input wire logic nmi_clear,
  // Sleep state
  input wire logic sleep_mode,
  // CPU side
  output irc_pkg::irc_cpu_req_t cpu_req,
  input wire logic cpu_ack,
  input wire logic [irc_pkg::VEC_W-1:0] cpu_ack_vec,
  // Transfer controller side
  output logic dtc_start,
  output logic [irc_pkg::VEC_W-1:0] dtc_vec,
  input wire logic dtc_ack,
  // Status
  output logic nmi_req,
  output logic [4:0] nmi_status,
  output logic [irc_pkg::NUM_SRC-1:0] pending,
  output logic wake_req
);

  localparam int NS = irc_pkg::NUM_SRC;
  localparam int PW = irc_pkg::PRIO_W;
  // Highest vector that names a real source; acks beyond it are ignored.
  localparam logic [irc_pkg::VEC_W-1:0] LAST_VEC = irc_pkg::VEC_W'(NS - 1);

  // Source map, lowest vector first:
  // peripherals, then the external pins, then the software source,
  // then the event link sources. The vector is the source index.
  // A limitation worth knowing: a level source cannot be cleared by an
  // acknowledge, it drops only when its input drops, so the handler must
  // quiet the peripheral before it returns or the request is seen again.
  // Edge sources are sticky instead, which costs one flag per source but
  // means a short pulse is never lost while a higher level is served.

  // ---------------------------------------------------------------
  // External pins: filter then detection
  // ---------------------------------------------------------------
  logic [NUM_EXT-1:0] ext_lvl;
  logic [NUM_EXT-1:0] ext_prev_r;
  logic [NUM_EXT-1:0] ext_prev_nxt;
  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_EXT-1:0] ext_is_level;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      irc_pin_filter u_filt (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(ext_request_pin[g]),
        .filt_en(ext_filt_en[g]),
        .filt_sel(ext_filt_sel[g*irc_pkg::FILT_SEL_W +: irc_pkg::FILT_SEL_W]),
        .level_out(ext_lvl[g])
      );
    end
  endgenerate

  // Decode one pin's mode into a hit; used for every external pin, not the NMI pin.
  function automatic logic det_hit(input logic [1:0] mode, input logic cur, input logic prv);
    case (irc_pkg::irc_det_t'(mode))
      irc_pkg::IRC_DET_LOW: det_hit = !cur;
      irc_pkg::IRC_DET_FALL: det_hit = prv && !cur;
      irc_pkg::IRC_DET_RISE: det_hit = !prv && cur;
      default: det_hit = prv != cur;
    endcase
  endfunction

  always_comb begin
    ext_prev_nxt = ext_lvl;
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_hit[i] = det_hit(ext_det_mode[i*2 +: 2], ext_lvl[i], ext_prev_r[i]);
      ext_is_level[i] = ext_det_mode[i*2 +: 2] == irc_pkg::IRC_DET_LOW;
    end
  end

  // ---------------------------------------------------------------
  // Peripheral edge detection and source vector assembly
  // ---------------------------------------------------------------
  logic [NUM_PERIPH-1:0] per_prev_r;
  logic [NUM_PERIPH-1:0] per_prev_nxt;
  logic [NS-1:0] src_hit;
  logic [NS-1:0] src_level;

  always_comb begin
    per_prev_nxt = periph_req;
    src_hit = '0;
    src_level = '0;
    for (int i = 0; i < NUM_PERIPH; i++) begin
      src_level[i] = !periph_edge_mode[i];
      src_hit[i] = periph_edge_mode[i] ? (periph_req[i] && !per_prev_r[i])
                                       : periph_req[i];
    end
    src_hit[irc_pkg::EXT_BASE +: NUM_EXT] = ext_hit;
    src_level[irc_pkg::EXT_BASE +: NUM_EXT] = ext_is_level;
    src_hit[irc_pkg::SW_IDX] = sw_trigger_wr;
    src_hit[irc_pkg::ELINK_BASE +: NUM_ELINK] = event_link_unit_evt;
  end

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  logic [NS-1:0] pend_r;
  logic [NS-1:0] pend_nxt;
  logic [NS-1:0] take;
  logic [NS-1:0] cand;
  logic win_valid;
  logic [irc_pkg::VEC_W-1:0] win_vec;
  logic [PW-1:0] win_prio;

  // A new hit in the clearing cycle wins so that no event is lost.
  // The ack vectors are range checked: a five-bit vector can name more
  // slots than there are sources, and a stray value must not clear one.
  // Both acks may land in one cycle; each clears only its own source.
  always_comb begin
    take = '0;
    if (cpu_ack && cpu_ack_vec <= LAST_VEC) begin
      take[cpu_ack_vec] = 1'b1;
    end
    if (dtc_ack && dtc_start && dtc_vec <= LAST_VEC) begin
      take[dtc_vec] = 1'b1;
    end
    // Level sources follow their input; edge sources hold until taken or cleared by sw_clear.
    for (int i = 0; i < NS; i++) begin
      if (src_level[i]) begin
        pend_nxt[i] = src_hit[i];
      end else begin
        pend_nxt[i] = src_hit[i] || (pend_r[i] && !take[i] && !sw_clear[i]);
      end
    end
  end

  assign cand = pend_r & src_enable;

  irc_arbiter #(
    .NUM_SRC(NS)
  ) u_arb (
    .cand(cand),
    .prio_flat(src_prio),
    .win_valid(win_valid),
    .win_vec(win_vec),
    .win_prio(win_prio)
  );

  // ---------------------------------------------------------------
  // Routing of the winner to the CPU or the transfer controller
  // ---------------------------------------------------------------
  irc_pkg::irc_cpu_req_t cpu_r;
  irc_pkg::irc_cpu_req_t cpu_nxt;
  logic dtc_start_r;
  logic dtc_start_nxt;
  logic [irc_pkg::VEC_W-1:0] dtc_vec_r;
  logic [irc_pkg::VEC_W-1:0] dtc_vec_nxt;
  logic to_dtc;

  // A transfer trigger source goes only to the controller; the CPU never sees it.
  // The start strobe drops in the cycle after the ack so that one request
  // starts one transfer, even while the pending flag is still being cleared.
  // The fast mark follows the winner, so it is only ever set for one source.
  always_comb begin
    to_dtc = win_valid && transfer_trigger_enable_reg[win_vec];
    cpu_nxt.req = win_valid && !to_dtc;
    cpu_nxt.vec = win_vec;
    cpu_nxt.prio = win_prio;
    cpu_nxt.fast = win_valid && fast_en && (win_vec == fast_vec);
    dtc_start_nxt = to_dtc && !(dtc_ack && dtc_start_r);
    dtc_vec_nxt = to_dtc ? win_vec : dtc_vec_r;
    if (cpu_ack) begin
      cpu_nxt.req = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Non-maskable sources
  // ---------------------------------------------------------------
  logic nmi_lvl;
  logic nmi_prev_r;
  logic nmi_prev_nxt;
  logic [4:0] nmi_stat_r;
  logic [4:0] nmi_stat_nxt;
  logic [4:0] nmi_evt;

  irc_pin_filter u_nmi_filt (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_in(nmi_pin),
    .filt_en(nmi_filt_en),
    .filt_sel(nmi_filt_sel),
    .level_out(nmi_lvl)
  );

  // Status bits are sticky; a clear never drops an arriving event.
  // The pin edge is taken after the filter, so the selected interval also
  // sets how soon a non-maskable pin request can be seen.
  // The other sources are same-clock logic and need no synchroniser.
  always_comb begin
    nmi_prev_nxt = nmi_lvl;
    nmi_evt[0] = nmi_enable && (nmi_rising ? (nmi_lvl && !nmi_prev_r)
                                            : (!nmi_lvl && nmi_prev_r));
    nmi_evt[1] = nmi_src.osc_stop;
    nmi_evt[2] = nmi_src.wdt_underflow || nmi_src.wdt_refresh_err;
    nmi_evt[3] = nmi_src.volt_mon_one;
    nmi_evt[4] = nmi_src.volt_mon_two;
    nmi_stat_nxt = nmi_evt | (nmi_clear ? 5'h00 : nmi_stat_r);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_prev_r <= '1;
      per_prev_r <= '0;
      pend_r <= '0;
      cpu_r <= '0;
      dtc_start_r <= 1'b0;
      dtc_vec_r <= irc_pkg::VEC_RST;
      nmi_prev_r <= 1'b1;
      nmi_stat_r <= 5'h00;
    end else if (clk_en) begin
      ext_prev_r <= ext_prev_nxt;
      per_prev_r <= per_prev_nxt;
      pend_r <= pend_nxt;
      cpu_r <= cpu_nxt;
      dtc_start_r <= dtc_start_nxt;
      dtc_vec_r <= dtc_vec_nxt;
      nmi_prev_r <= nmi_prev_nxt;
      nmi_stat_r <= nmi_stat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All data outputs come straight from flip-flops; only the summary
  // flags below are gates on registered state.
  assign cpu_req = cpu_r;
  assign dtc_start = dtc_start_r;
  assign dtc_vec = dtc_vec_r;
  assign nmi_status = nmi_stat_r;
  assign nmi_req = |nmi_stat_r;
  assign pending = pend_r;
  // Wake is combinational from registered state, sleep_mode and src_enable, so it needs no clock to settle.
  assign wake_req = sleep_mode && (nmi_req || |cand);

endmodule // irc_top

//--- verif/irc_checker_assertions.sv
// Checker for the interrupt request controller ports.
// Assumes a bind from the bench; one clock, rst async high.
`timescale 1ns/100ps
module irc_checker #(
  parameter int NUM_ELINK = irc_pkg::NUM_ELINK
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Watched inputs
  input wire logic sw_trigger_wr,
  input wire logic [NUM_ELINK-1:0] event_link_unit_evt,
  input wire logic [irc_pkg::NUM_SRC-1:0] transfer_trigger_enable_reg,
  input wire logic [irc_pkg::NUM_SRC-1:0] sw_clear,
  input wire logic fast_en,
  input wire logic [irc_pkg::VEC_W-1:0] fast_vec,
  input wire irc_pkg::irc_nmi_src_t nmi_src,
  input wire logic sleep_mode,
  input wire logic cpu_ack,
  input wire logic dtc_ack,
  // Watched outputs
  input wire irc_pkg::irc_cpu_req_t cpu_req,
  input wire logic dtc_start,
  input wire logic [irc_pkg::VEC_W-1:0] dtc_vec,
  input wire logic nmi_req,
  input wire logic [4:0] nmi_status,
  input wire logic [irc_pkg::NUM_SRC-1:0] pending
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // All checks share one clock; reset silences them.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sw_pend_a: assert property (clk_en && sw_trigger_wr |=> pending[24])
    else $error("software trigger not pending");
  link_pend_a: assert property (clk_en && event_link_unit_evt[0] |=> pending[25])
    else $error("event link not pending");
  osc_nmi_a: assert property (nmi_src.osc_stop |-> ##[1:2] nmi_status[1])
    else $error("oscillator stop lost");
  wdt_nmi_a: assert property ((nmi_src.wdt_underflow || nmi_src.wdt_refresh_err)
    |-> ##[1:2] nmi_status[2]) else $error("watchdog lost");
  vm_one_a: assert property (nmi_src.volt_mon_one |-> ##[1:2] (nmi_status[3] && nmi_req))
    else $error("monitor one lost");
  vm_two_a: assert property (nmi_src.volt_mon_two |-> ##[1:2] (nmi_status[4] && nmi_req))
    else $error("monitor two lost");
  edge_hold_a: assert property (clk_en && pending[24] && !cpu_ack && !dtc_ack
    && !sw_clear[24] |=> pending[24]) else $error("pending dropped");
  cpu_route_a: assert property (cpu_req.req |-> !transfer_trigger_enable_reg[cpu_req.vec])
    else $error("transfer source sent to cpu");
  dtc_route_a: assert property (dtc_start |-> transfer_trigger_enable_reg[dtc_vec])
    else $error("wrong transfer source");
  fast_one_a: assert property (cpu_req.fast |-> fast_en && cpu_req.vec == fast_vec)
    else $error("wrong fast source");

  // Main scenarios reached.
  cover property (cpu_req.req && cpu_ack);
  cover property (dtc_start && dtc_ack);
  cover property (sleep_mode && nmi_req);
endmodule // irc_checker

//--- verif/irc_cpu_model.sv
// Partner model: CPU core and transfer controller taking requests.
// Assumes irc_top ports; acknowledges are one-cycle strobes.
`timescale 1ns/100ps
module irc_cpu_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Cycles the CPU waits before taking a request
  input wire logic [3:0] ack_dly,
  // Requests
  input wire irc_pkg::irc_cpu_req_t cpu_req,
  input wire logic dtc_start,
  // Acknowledges
  output logic cpu_ack,
  output logic [irc_pkg::VEC_W-1:0] cpu_ack_vec,
  output logic dtc_ack
);
  logic [3:0] wait_cnt;

  // ---------------------------------------------------------------
  // Acknowledge timing
  // ---------------------------------------------------------------
  // While no request is up the vector toggles, so reading it then is never lucky.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      cpu_ack_vec <= 5'h00;
      dtc_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      dtc_ack <= dtc_start && !dtc_ack;
      if (cpu_ack || !cpu_req.req) begin
        cpu_ack <= 1'b0;
        cpu_ack_vec <= ~cpu_ack_vec;
        wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_dly) begin
        cpu_ack <= 1'b1;
        cpu_ack_vec <= cpu_req.vec;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // irc_cpu_model

//--- verif/tb_interrupt_request_controller.sv
// Testbench for the interrupt request controller.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/100ps
module tb_interrupt_request_controller;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en, sw_trigger_wr, fast_en, nmi_pin, nmi_rising, nmi_enable, nmi_clear;
  logic sleep_mode, nmi_filt_en, cpu_ack, dtc_ack, dtc_start, nmi_req, wake_req;
  logic [15:0] periph_req, periph_edge_mode, ext_det_mode, ext_filt_sel;
  logic [7:0] ext_request_pin, ext_filt_en;
  logic [1:0] event_link_unit_evt, nmi_filt_sel;
  logic [26:0] src_enable, transfer_trigger_enable_reg, sw_clear, pending;
  logic [107:0] src_prio;
  logic [4:0] fast_vec, cpu_ack_vec, dtc_vec, nmi_status;
  logic [3:0] ack_dly;
  irc_pkg::irc_nmi_src_t nmi_src;
  irc_pkg::irc_cpu_req_t cpu_req;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Status bit expected for each one-hot value of the source struct.
  localparam logic [4:0] NMI_EXP [5] = '{5'h10, 5'h08, 5'h04, 5'h04, 5'h02};

  irc_top dut_u (.ref_clk, .rst, .clk_en, .periph_req, .periph_edge_mode, .ext_request_pin,
    .event_link_unit_evt, .sw_trigger_wr, .ext_det_mode, .ext_filt_en, .ext_filt_sel,
    .src_enable, .src_prio, .transfer_trigger_enable_reg, .sw_clear, .fast_en, .fast_vec,
    .nmi_pin, .nmi_rising, .nmi_filt_en, .nmi_filt_sel, .nmi_enable, .nmi_src, .nmi_clear,
    .sleep_mode, .cpu_req, .cpu_ack, .cpu_ack_vec, .dtc_start, .dtc_vec, .dtc_ack,
    .nmi_req, .nmi_status, .pending, .wake_req);
  irc_cpu_model cpu_u (.ref_clk, .rst, .ack_dly, .cpu_req, .dtc_start, .cpu_ack,
    .cpu_ack_vec, .dtc_ack);

  // Clock and a hang limit far above the well under two thousand cycles needed.
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Bounded wait for the CPU request or the transfer start.
  task automatic wait_out(input bit to_dtc);
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if ((to_dtc ? dtc_start : cpu_req.req) === 1'b1) break;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_sw;
    cyc(1);
    src_prio[99:96] <= 4'h3;
    sw_trigger_wr <= 1'b1;
    cyc(1);
    sw_trigger_wr <= 1'b0;
    wait_out(1'b0);
    chk({cpu_req.vec, cpu_req.prio}, {5'h18, 4'h3}, "sw vector");
    cyc(4);
    @(negedge ref_clk);
    chk({cpu_req.req, pending[24]}, 2'b00, "sw taken");
  endtask
  task automatic t_periph;
    cyc(1);
    ack_dly <= 4'hf;
    periph_edge_mode <= 16'h0040;
    src_prio[23:20] <= 4'h5;
    src_prio[15:12] <= 4'h2;
    periph_req <= 16'h00e8;
    cyc(1);
    periph_req <= 16'h0028;
    cyc(4);
    @(negedge ref_clk);
    chk(cpu_req.vec, 5, "higher level");
    chk(pending[7:6], 2'b01, "edge vs level");
    cyc(1);
    src_prio[15:12] <= 4'h5;
    sw_clear <= 27'h40;
    cyc(1);
    sw_clear <= 27'h0;
    cyc(3);
    @(negedge ref_clk);
    chk(cpu_req.vec, 3, "tie");
    chk(pending[6], 0, "sw clear");
    cyc(1);
    periph_req <= 16'h0;
    src_prio <= '0;
    ack_dly <= 4'h0;
  endtask
  task automatic t_pins;
    for (int m = 0; m < 4; m++) begin
      cyc(1);
      ext_det_mode[1:0] <= m[1:0];
      sw_clear[16] <= 1'b1;
      cyc(1);
      sw_clear[16] <= 1'b0;
      ext_request_pin[0] <= 1'b0;
      cyc(12);
      @(negedge ref_clk);
      chk(pending[16], m != 2, "pin low");
      cyc(1);
      ext_request_pin[0] <= 1'b1;
      cyc(12);
      @(negedge ref_clk);
      chk(pending[16], m != 0, "pin high");
    end
    cyc(1);
    ext_det_mode <= 16'h0;
    ext_request_pin <= 8'h5a;
    cyc(12);
    @(negedge ref_clk);
    chk(pending[23:16], 8'ha5, "eight pins");
    cyc(1);
    ext_request_pin <= 8'hff;
  endtask
  task automatic t_filter;
    cyc(12);
    ext_det_mode <= 16'h0001;
    ext_filt_en <= 8'h01;
    ext_filt_sel <= 16'h0003;
    cyc(300);
    ext_request_pin[0] <= 1'b0;
    cyc(20);
    ext_request_pin[0] <= 1'b1;
    cyc(300);
    @(negedge ref_clk);
    chk(pending[16], 0, "glitch");
    cyc(1);
    ext_request_pin[0] <= 1'b0;
    cyc(300);
    @(negedge ref_clk);
    chk(pending[16], 1, "long low");
  endtask
  task automatic t_dtc;
    cyc(1);
    transfer_trigger_enable_reg[24] <= 1'b1;
    src_prio[99:96] <= 4'h3;
    sw_trigger_wr <= 1'b1;
    cyc(1);
    sw_trigger_wr <= 1'b0;
    wait_out(1'b1);
    chk({cpu_req.req, dtc_vec}, {1'b0, 5'h18}, "transfer");
    cyc(4);
    @(negedge ref_clk);
    chk({dtc_start, pending[24]}, 2'b00, "transfer taken");
    cyc(1);
    transfer_trigger_enable_reg <= '0;
  endtask
  task automatic t_fast;
    cyc(1);
    fast_en <= 1'b1;
    fast_vec <= 5'h19;
    src_prio[103:100] <= 4'h2;
    event_link_unit_evt <= 2'b01;
    cyc(1);
    event_link_unit_evt <= 2'b10;
    cyc(1);
    event_link_unit_evt <= 2'b00;
    wait_out(1'b0);
    chk({cpu_req.fast, cpu_req.vec, pending[26]}, {1'b1, 5'h19, 1'b1}, "fast");
  endtask
  task automatic t_nmi;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      nmi_src <= 5'h01 << i;
      sleep_mode <= 1'b1;
      cyc(1);
      nmi_src <= 5'h00;
      cyc(2);
      @(negedge ref_clk);
      chk({nmi_req, wake_req, nmi_status}, {2'b11, NMI_EXP[i]}, "nmi source");
      cyc(1);
      nmi_clear <= 1'b1;
      sleep_mode <= 1'b0;
      cyc(1);
      nmi_clear <= 1'b0;
    end
    for (int r = 0; r < 2; r++) begin
      cyc(1);
      nmi_enable <= 1'b1;
      nmi_rising <= r[0];
      nmi_pin <= !r[0];
      cyc(12);
      nmi_clear <= 1'b1;
      cyc(1);
      nmi_clear <= 1'b0;
      nmi_pin <= r[0];
      cyc(12);
      @(negedge ref_clk);
      chk(nmi_status, 5'h01, "nmi pin");
    end
  endtask

  // Main sequence: every input set at time zero, reset, then the scenarios.
  initial begin
    {clk_en, nmi_pin} = 2'b11;
    {sw_trigger_wr, fast_en, nmi_rising, nmi_enable, nmi_clear} = '0;
    {sleep_mode, nmi_filt_en, periph_req, periph_edge_mode, ext_det_mode} = '0;
    {ext_filt_sel, ext_filt_en, event_link_unit_evt, nmi_filt_sel} = '0;
    {transfer_trigger_enable_reg, sw_clear, src_prio, fast_vec, ack_dly} = '0;
    nmi_src = '0;
    src_enable = '1;
    ext_request_pin = 8'hff;
    cyc(16);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk({cpu_req, dtc_start, nmi_req, pending[18:0]}, 0, "reset");
    t_sw();
    t_periph();
    t_pins();
    t_filter();
    t_dtc();
    t_fast();
    t_nmi();
    print_verdict();
  end
endmodule // tb_interrupt_request_controller

bind irc_top irc_checker #(.NUM_ELINK(NUM_ELINK)) chk_u (.ref_clk, .rst, .clk_en,
  .sw_trigger_wr, .event_link_unit_evt, .transfer_trigger_enable_reg, .sw_clear, .fast_en,
  .fast_vec, .nmi_src, .sleep_mode, .cpu_ack, .dtc_ack, .cpu_req, .dtc_start, .dtc_vec,
  .nmi_req, .nmi_status, .pending);
